// ### include/adc_ctrl_pkg.sv
package adc_ctrl_pkg;

  // Register port geometry
  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;

  // Register offsets
  localparam logic [11:0] OFF_SYNC_COUNT = 12'h210;
  localparam logic [11:0] OFF_OVERRANGE_THRESHOLD     = 12'h211;
  localparam logic [11:0] OFF_OVERRANGE_CONFIG    = 12'h213;
  localparam logic [11:0] OFF_INIT       = 12'h270;
  localparam logic [11:0] OFF_PWR2       = 12'h29a;

  // Field layout
  localparam int SYNC_COUNT_W  = 5;
  localparam int OVERRANGE_OUTPUT_ENABLE_BIT    = 3;
  localparam int OVR_EXT_W     = 3;
  localparam int INIT_DONE_BIT = 0;

  // Reset values
  localparam logic [4:0] RST_SYNC_COUNT = 5'h03;
  localparam logic [7:0] RST_OVERRANGE_THRESHOLD     = 8'hf2;
  localparam logic       RST_OVERRANGE_OUTPUT_ENABLE     = 1'b0;
  localparam logic [2:0] RST_OVR_EXT    = 3'h7;
  localparam logic [7:0] RST_PWR2       = 8'h0f;
  localparam logic [7:0] RD_ZERO        = 8'h00;

  // Power mode codes of the second power-mode register
  localparam logic [7:0] PWR2_LOW_POWER = 8'h06;
  localparam logic [7:0] PWR2_HIGH_PERF = 8'h0f;

  // Sampling and over-range timing
  localparam int SAMPLE_W          = 9;
  localparam int SAMPLES_PER_LINK  = 2;
  localparam int PULSE_BASE_SAMPLES = 4;
  localparam int HOLD_W            = 9;
  localparam int RUN_W             = 6;

  // SYNC~ classifier states
  typedef enum logic [1:0] {
    SYNC_IDLE     = 2'b00,
    SYNC_COUNTING = 2'b01,
    SYNC_REQUEST  = 2'b10
  } sync_state_e;

endpackage

// ### include/overrange_config_if.sv
interface overrange_config_if;
  logic [7:0] threshold;
  logic       enable;
  logic [2:0] extension;

  modport source (
    output threshold,
    output enable,
    output extension
  );

  modport sink (
    input threshold,
    input enable,
    input extension
  );
endinterface

// ### design/overrange_channel.sv
module overrange_channel (
  input  wire logic         clk,
  input  wire logic         rst,
  overrange_config_if.sink           cfg,
  input  wire logic [17:0]  samples,
  output logic              over_out
);

  localparam int SW = adc_ctrl_pkg::SAMPLE_W;
  localparam int HW = adc_ctrl_pkg::HOLD_W;
  localparam logic [HW-1:0] BASE_HOLD = HW'(
    adc_ctrl_pkg::PULSE_BASE_SAMPLES / adc_ctrl_pkg::SAMPLES_PER_LINK);
  localparam logic [HW-1:0] HOLD_ZERO = '0;
  localparam logic [HW-1:0] HOLD_ONE  = HW'(1);

  logic [SW-1:0] mag0;
  logic [SW-1:0] mag1;
  logic          hit;
  logic [HW-1:0] hold_len;
  logic [HW-1:0] hold_ff;
  logic          over_ff;

  // Magnitude of each signed sample; -256 gives 256, full scale
  function automatic logic [SW-1:0] magnitude(input logic [SW-1:0] s);
    magnitude = s[SW-1] ? SW'(~s + 1'b1) : s;
  endfunction

  // Two samples arrive per link clock; either one may trip
  always_comb
  begin
    mag0 = magnitude(samples[SW-1:0]);
    mag1 = magnitude(samples[2*SW-1:SW]);
    hit  = (mag0 >= {1'b0, cfg.threshold}) ||
           (mag1 >= {1'b0, cfg.threshold});
    // 4 * 2^N sample periods, two samples per link clock
    hold_len = BASE_HOLD << cfg.extension;
  end

  // Pulse stretcher; retriggers on every new hit
  always_ff @(posedge clk)
  begin
    if (rst || !cfg.enable)
    begin
      hold_ff <= HOLD_ZERO;
      over_ff <= 1'b0;
    end
    else if (hit)
    begin
      hold_ff <= hold_len - HOLD_ONE;
      over_ff <= 1'b1;
    end
    else if (hold_ff != HOLD_ZERO)
    begin
      hold_ff <= hold_ff - HOLD_ONE;
      over_ff <= 1'b1;
    end
    else
    begin
      over_ff <= 1'b0;
    end
  end

  assign over_out = over_ff;

endmodule // overrange_channel

// ### design/adc_sync_overrange_ctrl.sv
module adc_sync_overrange_ctrl (
  input  wire logic        clk,
  input  wire logic        rst,
  // Decoded configuration register port
  input  wire logic [11:0] reg_addr,
  input  wire logic        reg_wr_en,
  input  wire logic        reg_rd_en,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  output logic             reg_rvalid,
  // Link side
  input  wire logic        link_enable,
  input  wire logic        sync_n,
  output logic             sync_request,
  output logic             sync_request_start,
  // Initialization engine
  input  wire logic        init_done_in,
  // Converter samples, two per link clock per channel
  input  wire logic [17:0] sample_a,
  input  wire logic [17:0] sample_b,
  input  wire logic [17:0] sample_c,
  input  wire logic [17:0] sample_d,
  output logic             overrange_out_a,
  output logic             overrange_out_b,
  output logic             overrange_out_c,
  output logic             overrange_out_d,
  // Power mode to the analog core
  output logic      [7:0]  power_mode_code_second,
  output logic             power_low_select,
  output logic             power_high_select
);

  localparam int CW = adc_ctrl_pkg::SYNC_COUNT_W;
  localparam int RW = adc_ctrl_pkg::RUN_W;
  localparam logic [RW-1:0] RUN_ZERO = '0;
  localparam logic [RW-1:0] RUN_ONE  = RW'(1);

  // Register state
  logic [CW-1:0] sync_request_count_ff;
  logic [7:0]    overrange_threshold_ff;
  logic          overrange_output_enable_ff;
  logic [2:0]    overrange_pulse_extension_ff;
  logic [7:0]    power_mode_second_ff;
  logic          init_done_ff;
  logic [7:0]    rdata_ff;
  logic          rvalid_ff;

  // Write strobes
  logic wr_sync;
  logic wr_th;
  logic wr_cfg;
  logic wr_pwr2;

  // SYNC~ classifier
  adc_ctrl_pkg::sync_state_e state_ff;
  adc_ctrl_pkg::sync_state_e nxt_state;
  logic [RW-1:0] run_ff;
  logic [RW-1:0] nxt_run;
  logic [RW-1:0] run_target;
  logic          start_ff;
  logic          nxt_start;

  // Read path
  logic [7:0] nxt_rdata;
  logic [7:0] cfg_view;

  // Address decode; writes to other offsets fall away silently
  always_comb
  begin
    wr_sync = reg_wr_en && (reg_addr == adc_ctrl_pkg::OFF_SYNC_COUNT);
    wr_th   = reg_wr_en && (reg_addr == adc_ctrl_pkg::OFF_OVERRANGE_THRESHOLD);
    wr_cfg  = reg_wr_en && (reg_addr == adc_ctrl_pkg::OFF_OVERRANGE_CONFIG);
    wr_pwr2 = reg_wr_en && (reg_addr == adc_ctrl_pkg::OFF_PWR2);
  end

  // Sync count; takes effect at once, so change it with the link off
  always_ff @(posedge clk)
  begin
    if (rst)
      sync_request_count_ff <= adc_ctrl_pkg::RST_SYNC_COUNT;
    else if (wr_sync)
      sync_request_count_ff <= reg_wdata[CW-1:0];
  end

  // Over-range threshold
  always_ff @(posedge clk)
  begin
    if (rst)
      overrange_threshold_ff <= adc_ctrl_pkg::RST_OVERRANGE_THRESHOLD;
    else if (wr_th)
      overrange_threshold_ff <= reg_wdata;
  end

  // Over-range enable and pulse extension
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      overrange_output_enable_ff   <= adc_ctrl_pkg::RST_OVERRANGE_OUTPUT_ENABLE;
      overrange_pulse_extension_ff <= adc_ctrl_pkg::RST_OVR_EXT;
    end
    else if (wr_cfg)
    begin
      overrange_output_enable_ff   <=
        reg_wdata[adc_ctrl_pkg::OVERRANGE_OUTPUT_ENABLE_BIT];
      overrange_pulse_extension_ff <=
        reg_wdata[adc_ctrl_pkg::OVR_EXT_W-1:0];
    end
  end

  // Second power-mode code; reserved codes are stored as written
  always_ff @(posedge clk)
  begin
    if (rst)
      power_mode_second_ff <= adc_ctrl_pkg::RST_PWR2;
    else if (wr_pwr2)
      power_mode_second_ff <= reg_wdata;
  end

  // Init-done status follows the init engine, registered once
  always_ff @(posedge clk)
  begin
    if (rst)
      init_done_ff <= 1'b0;
    else
      init_done_ff <= init_done_in;
  end

  // Power mode decode; a reserved code selects neither mode
  always_comb
  begin
    power_mode_code_second = power_mode_second_ff;
    power_low_select  =
      (power_mode_second_ff == adc_ctrl_pkg::PWR2_LOW_POWER);
    power_high_select =
      (power_mode_second_ff == adc_ctrl_pkg::PWR2_HIGH_PERF);
  end

  // Low run length needed before a request is accepted
  assign run_target = RW'(sync_request_count_ff) + RUN_ONE;

  // SYNC~ classifier, one sample per link clock edge
  always_comb
  begin
    nxt_state = state_ff;
    nxt_run   = run_ff;
    nxt_start = 1'b0;
    case (state_ff)
      adc_ctrl_pkg::SYNC_IDLE:
      begin
        nxt_run = RUN_ZERO;
        if (link_enable && !sync_n)
        begin
          if (RUN_ONE >= run_target)
          begin
            nxt_state = adc_ctrl_pkg::SYNC_REQUEST;
            nxt_start = 1'b1;
          end
          else
          begin
            nxt_state = adc_ctrl_pkg::SYNC_COUNTING;
            nxt_run   = RUN_ONE;
          end
        end
      end
      adc_ctrl_pkg::SYNC_COUNTING:
      begin
        if (!link_enable || sync_n)
        begin
          // Short low pulse: an error report, dropped without trace
          nxt_state = adc_ctrl_pkg::SYNC_IDLE;
          nxt_run   = RUN_ZERO;
        end
        else if (run_ff + RUN_ONE >= run_target)
        begin
          nxt_state = adc_ctrl_pkg::SYNC_REQUEST;
          nxt_start = 1'b1;
          nxt_run   = RUN_ZERO;
        end
        else
        begin
          nxt_run = run_ff + RUN_ONE;
        end
      end
      adc_ctrl_pkg::SYNC_REQUEST:
      begin
        nxt_run = RUN_ZERO;
        if (!link_enable || sync_n)
          nxt_state = adc_ctrl_pkg::SYNC_IDLE;
      end
      default:
      begin
        nxt_state = adc_ctrl_pkg::SYNC_IDLE;
        nxt_run   = RUN_ZERO;
      end
    endcase
  end

  // Classifier state
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_ff <= adc_ctrl_pkg::SYNC_IDLE;
      run_ff   <= RUN_ZERO;
      start_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      run_ff   <= nxt_run;
      start_ff <= nxt_start;
    end
  end

  // Request level holds while SYNC~ stays low and link_enable stays high after qualification
  assign sync_request       = (state_ff == adc_ctrl_pkg::SYNC_REQUEST);
  assign sync_request_start = start_ff;

  // Configuration byte as read back, reserved bits zero
  always_comb
  begin
    cfg_view = adc_ctrl_pkg::RD_ZERO;
    cfg_view[adc_ctrl_pkg::OVERRANGE_OUTPUT_ENABLE_BIT] = overrange_output_enable_ff;
    cfg_view[adc_ctrl_pkg::OVR_EXT_W-1:0] = overrange_pulse_extension_ff;
  end

  // Read mux; unmapped offsets return zero
  always_comb
  begin
    nxt_rdata = adc_ctrl_pkg::RD_ZERO;
    case (reg_addr)
      adc_ctrl_pkg::OFF_SYNC_COUNT:
        nxt_rdata = {{(8-CW){1'b0}}, sync_request_count_ff};
      adc_ctrl_pkg::OFF_OVERRANGE_THRESHOLD:
        nxt_rdata = overrange_threshold_ff;
      adc_ctrl_pkg::OFF_OVERRANGE_CONFIG:
        nxt_rdata = cfg_view;
      adc_ctrl_pkg::OFF_INIT:
        nxt_rdata[adc_ctrl_pkg::INIT_DONE_BIT] = init_done_ff;
      adc_ctrl_pkg::OFF_PWR2:
        nxt_rdata = power_mode_second_ff;
      default:
        nxt_rdata = adc_ctrl_pkg::RD_ZERO;
    endcase
  end

  // Read data is registered; it stands until the next read
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rdata_ff  <= adc_ctrl_pkg::RD_ZERO;
      rvalid_ff <= 1'b0;
    end
    else
    begin
      rvalid_ff <= reg_rd_en;
      if (reg_rd_en)
        rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata  = rdata_ff;
  assign reg_rvalid = rvalid_ff;

  // Shared over-range configuration for all channel detectors
  overrange_config_if overrange_config ();

  assign overrange_config.threshold = overrange_threshold_ff;
  assign overrange_config.enable    = overrange_output_enable_ff;
  assign overrange_config.extension = overrange_pulse_extension_ff;

  // One independent detector per channel
  overrange_channel u_ovr_a (
    .clk      (clk),
    .rst      (rst),
    .cfg      (overrange_config),
    .samples  (sample_a),
    .over_out (overrange_out_a)
  );

  overrange_channel u_ovr_b (
    .clk      (clk),
    .rst      (rst),
    .cfg      (overrange_config),
    .samples  (sample_b),
    .over_out (overrange_out_b)
  );

  overrange_channel u_ovr_c (
    .clk      (clk),
    .rst      (rst),
    .cfg      (overrange_config),
    .samples  (sample_c),
    .over_out (overrange_out_c)
  );

  overrange_channel u_ovr_d (
    .clk      (clk),
    .rst      (rst),
    .cfg      (overrange_config),
    .samples  (sample_d),
    .over_out (overrange_out_d)
  );

endmodule // adc_sync_overrange_ctrl

// ### bench/adc_ctrl_asserts.sv
module adc_ctrl_asserts (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [11:0] reg_addr,
  input wire logic        reg_wr_en,
  input wire logic        reg_rd_en,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_rvalid,
  input wire logic        link_enable,
  input wire logic        sync_n,
  input wire logic        sync_request,
  input wire logic        sync_request_start,
  input wire logic [17:0] sample_a,
  input wire logic        overrange_out_a,
  input wire logic        overrange_out_b,
  input wire logic        overrange_out_c,
  input wire logic        overrange_out_d,
  input wire logic [7:0]  power_mode_code_second,
  input wire logic        power_low_select,
  input wire logic        power_high_select
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic [4:0] k_ff;
  logic [5:0] run_ff;
  logic [7:0] thr_ff;
  logic       en_ff;
  logic [2:0] ext_ff;
  logic [8:0] hi_ff;
  logic       hit_a;
  // Magnitude of a signed sample; the most negative gives 256
  function automatic logic [8:0] mag(input logic [8:0] s);
    return s[8] ? 9'h000 - s : s;
  endfunction
  assign hit_a = (mag(sample_a[8:0]) >= {1'b0, thr_ff})
              || (mag(sample_a[17:9]) >= {1'b0, thr_ff});
  // Shadow of the fields; mirrors writes on the same edge
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      k_ff   <= 5'h03;
      thr_ff <= 8'hf2;
      en_ff  <= 1'b0;
      ext_ff <= 3'h7;
    end
    else if (reg_wr_en && reg_addr == 12'h210)
      k_ff <= reg_wdata[4:0];
    else if (reg_wr_en && reg_addr == 12'h211)
      thr_ff <= reg_wdata;
    else if (reg_wr_en && reg_addr == 12'h213)
    begin
      en_ff  <= reg_wdata[3];
      ext_ff <= reg_wdata[2:0];
    end
  end
  // Low run length; saturates so long runs never wrap
  always_ff @(posedge clk)
  begin
    if (rst || !link_enable || sync_n)
      run_ff <= 6'h00;
    else if (run_ff != 6'h3f)
      run_ff <= run_ff + 6'h01;
  end
  // Cycles the channel A output has stood high
  always_ff @(posedge clk)
  begin
    if (rst || !overrange_out_a)
      hi_ff <= 9'h000;
    else if (hi_ff != 9'h1ff)
      hi_ff <= hi_ff + 9'h001;
  end
  sequence low_run_met;
    run_ff == {1'b0, k_ff} + 6'h01;
  endsequence
  sequence hit_seen;
    en_ff && hit_a;
  endsequence
  sync_fire_a: assert property (low_run_met |-> sync_request_start
    ##1 !sync_request_start) else $error("sync start missing");
  sync_start_a: assert property (sync_request_start |-> low_run_met)
    else $error("sync start without full run");
  sync_quiet_a: assert property (run_ff <= {1'b0, k_ff}
    |-> !sync_request) else $error("short run made a request");
  sync_drop_a: assert property (!link_enable |=> !sync_request)
    else $error("request while link disabled");
  ovr_hit_a: assert property (hit_seen |=> overrange_out_a [*2])
    else $error("over-range hit not reported");
  ovr_off_a: assert property (!en_ff |=> !(overrange_out_a ||
    overrange_out_b || overrange_out_c || overrange_out_d))
    else $error("over-range output while disabled");
  ovr_hold_a: assert property ($fell(overrange_out_a) && en_ff
    |-> hi_ff >= (9'h002 << ext_ff)) else $error("over-range too short");
  read_valid_a: assert property (reg_rvalid == $past(reg_rd_en))
    else $error("read valid misplaced");
  power_sel_a: assert property (
    power_low_select == (power_mode_code_second == 8'h06) &&
    power_high_select == (power_mode_code_second == 8'h0f))
    else $error("power select decode wrong");
endmodule // adc_ctrl_asserts

bind adc_sync_overrange_ctrl adc_ctrl_asserts u_adc_ctrl_asserts (
  .clk, .rst, .reg_addr, .reg_wr_en, .reg_rd_en, .reg_wdata, .reg_rvalid,
  .link_enable, .sync_n, .sync_request, .sync_request_start, .sample_a,
  .overrange_out_a, .overrange_out_b, .overrange_out_c, .overrange_out_d,
  .power_mode_code_second, .power_low_select, .power_high_select
);

// ### bench/sync_rx_model.sv
module sync_rx_model (
  input  wire logic       clk,
  input  wire logic       go,
  input  wire logic [5:0] low_len,
  output logic            sync_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic       armed_ff;
  logic [5:0] left_ff;
  initial
  begin
    armed_ff = 1'b0;
    left_ff = 6'h00;
    sync_n = 1'b1;
  end
  // Request latched on the rising edge so the bench may raise it freely
  always @(posedge clk)
    armed_ff <= go;
  // Low for low_len link clocks, else idle high: a short low_len gives an error report
  always @(negedge clk)
  begin
    if (armed_ff)
    begin
      sync_n  <= 1'b0;
      left_ff <= low_len - 6'h01;
    end
    else if (left_ff != 6'h00)
      left_ff <= left_ff - 6'h01;
    else
      sync_n <= 1'b1;
  end
endmodule // sync_rx_model

// ### bench/adc_sync_overrange_ctrl_tb.sv
module adc_sync_overrange_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [11:0] reg_addr = 12'h000;
  logic        reg_wr_en = 1'b0;
  logic        reg_rd_en = 1'b0;
  logic [7:0]  reg_wdata = 8'h00;
  logic [7:0]  reg_rdata;
  logic        reg_rvalid;
  logic        link_enable = 1'b0;
  logic        sync_n;
  logic        sync_request;
  logic        sync_request_start;
  logic        init_done_in = 1'b0;
  logic [17:0] smp [4] = '{default: 18'h00000};
  wire  [3:0]  ovr;
  logic [7:0]  pwr_code;
  logic        pwr_low;
  logic        pwr_high;
  logic        go = 1'b0;
  logic [5:0]  low_len = 6'h01;
  int          err_total = 0;
  int          n_checks = 0;

  // 10 MHz link clock
  always #50 clk = ~clk;

  adc_sync_overrange_ctrl u_adc_sync_overrange_ctrl (
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .link_enable(link_enable), .sync_n(sync_n),
    .sync_request(sync_request), .sync_request_start(sync_request_start),
    .init_done_in(init_done_in), .sample_a(smp[0]), .sample_b(smp[1]),
    .sample_c(smp[2]), .sample_d(smp[3]), .overrange_out_a(ovr[0]),
    .overrange_out_b(ovr[1]), .overrange_out_c(ovr[2]),
    .overrange_out_d(ovr[3]), .power_mode_code_second(pwr_code),
    .power_low_select(pwr_low), .power_high_select(pwr_high)
  );
  sync_rx_model u_sync_rx_model (
    .clk(clk), .go(go), .low_len(low_len), .sync_n(sync_n)
  );

  task automatic complete_run;
    if (err_total == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    n_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr_en = 1'b1;
    @(negedge clk);
    reg_wr_en = 1'b0;
  endtask
  // Read data is taken in the cycle after the strobe, where valid stands
  task automatic rd(input logic [11:0] a, input logic [7:0] exp);
    @(negedge clk);
    reg_addr = a;
    reg_rd_en = 1'b1;
    @(negedge clk);
    reg_rd_en = 1'b0;
    chk("rvalid", 16'h0001, reg_rvalid);
    chk("rdata", exp, reg_rdata);
  endtask
  task automatic t_regs;
    rd(12'h270, 8'h01);
    rd(12'h211, 8'hf2);
    rd(12'h213, 8'h07);
    rd(12'h210, 8'h03);
    rd(12'h29a, 8'h0f);
    rd(12'h212, 8'h00);
    wr(12'h270, 8'hfe);
    rd(12'h270, 8'h01);
  endtask
  task automatic t_power;
    logic [7:0] codes [3] = '{8'h06, 8'h05, 8'h0f};
    link_enable = 1'b0;
    // Calibration lies outside; no conversion is judged here
    foreach (codes[i])
    begin
      wr(12'h29a, codes[i]);
      rd(12'h29a, codes[i]);
      chk("low_sel", codes[i] == 8'h06, pwr_low);
      chk("high_sel", codes[i] == 8'h0f, pwr_high);
      chk("code", codes[i], pwr_code);
    end
  endtask
  // Returns the cycle of the request pulse, counted from the first low
  task automatic pulse_sync(input logic [5:0] len, output int at);
    at = 0;
    @(negedge clk);
    low_len = len;
    go = 1'b1;
    @(negedge clk);
    go = 1'b0;
    for (int i = 1; i < 40; i++)
    begin
      @(negedge clk);
      if (sync_request_start === 1'b1 && at == 0)
        at = i;
    end
  endtask
  task automatic t_sync(input logic [4:0] k);
    int at;
    link_enable = 1'b0;
    wr(12'h210, {3'h0, k});
    link_enable = 1'b1;
    if (k != 5'h00)
    begin
      pulse_sync({1'b0, k}, at);
      chk("short_run", 16'h0000, at);
    end
    pulse_sync({1'b0, k} + 6'h01, at);
    chk("full_run", k + 16'h0001, at);
    chk("req_drop", 16'h0000, sync_request);
    link_enable = 1'b0;
    pulse_sync({1'b0, k} + 6'h01, at);
    chk("link_off", 16'h0000, at);
  endtask
  // Link switched off while a request stands; the level must drop
  task automatic t_link_drop;
    wr(12'h210, 8'h00);
    link_enable = 1'b1;
    low_len = 6'h20;
    @(negedge clk);
    go = 1'b1;
    @(negedge clk);
    go = 1'b0;
    repeat (8) @(negedge clk);
    chk("req_hold", 16'h0001, sync_request);
    link_enable = 1'b0;
    @(negedge clk);
    chk("req_off", 16'h0000, sync_request);
    repeat (40) @(negedge clk);
  endtask
  // One hit on one channel; measures how long its output stands
  task automatic ovr_case(input logic [7:0] cfg, input int ch,
                          input logic [17:0] v, input int exp);
    int len;
    logic [3:0] first;
    wr(12'h213, cfg);
    len = 0;
    @(negedge clk);
    smp[ch] = v;
    @(negedge clk);
    smp[ch] = 18'h00000;
    first = ovr;
    while (ovr[ch] === 1'b1 && len < 600)
    begin
      len++;
      @(negedge clk);
    end
    chk("ovr_len", exp, len);
    chk("ovr_first", exp ? (16'h0001 << ch) : 16'h0000, first);
  endtask

  // Watchdog: the sequence needs under a thousand cycles
  initial
  begin
    repeat (20000) @(posedge clk);
    err_total++;
    complete_run();
  end
  initial
  begin
    repeat (20) @(negedge clk);
    rst = 1'b0;
    init_done_in = 1'b1;
    repeat (3) @(negedge clk);
    t_regs();
    t_power();
    t_sync(5'h00);
    t_sync(5'h03);
    t_sync(5'h1f);
    t_link_drop();
    wr(12'h211, 8'h80);
    ovr_case(8'h08, 0, 18'h00080, 2);
    ovr_case(8'h08, 1, 18'h0007f, 0);
    ovr_case(8'h08, 2, 18'h00180, 2);
    ovr_case(8'h08, 3, 18'h10000, 2);
    ovr_case(8'h0a, 0, 18'h00100, 8);
    ovr_case(8'h0f, 1, 18'h000ff, 256);
    ovr_case(8'h07, 0, 18'h000ff, 0);
    complete_run();
  end
endmodule // adc_sync_overrange_ctrl_tb
